// >>> rtl/eram_pkg.sv
// Purpose: Shared constants and carriers of the expanded RAM address mapper.
// Assumes: One 25 MHz core clock; core-side requests come from same-clock logic.
// Notes:   Register offsets are core special-register addresses.
package eram_pkg;

  // Register addresses on the core special-register port
  localparam logic [7:0]  ERAM_OFS_PAGE      = 8'h85;  // ri_page_register
  localparam logic [7:0]  ERAM_OFS_BANK      = 8'h86;  // direct_bank_register
  localparam logic [7:0]  ERAM_OFS_SYSCFG    = 8'hbf;  // system_config_register

  // Values after reset
  localparam logic [7:0]  ERAM_RST_PAGE      = 8'h00;
  localparam logic [7:0]  ERAM_RST_BANK      = 8'h01;
  localparam logic [7:0]  ERAM_RST_SYSCFG    = 8'h02;

  // Field positions
  localparam int          ERAM_POS_XEN       = 1;      // xram_enable in system config
  localparam int          ERAM_POS_BANK_EN   = 7;      // banking_enable in bank register
  localparam int          ERAM_POS_PAGE_HI   = 1;      // page_select_high
  localparam int          ERAM_POS_PAGE_LO   = 0;      // page_select_low
  localparam int          ERAM_POS_BANK_HI   = 3;      // top bit of bank_number

  // Address map figures
  localparam logic [15:0] ERAM_XRAM_SIZE     = 16'h0300; // 768 bytes on chip
  localparam logic [1:0]  ERAM_PAGE_OFFCHIP  = 2'h3;     // page code that leaves the chip
  localparam logic [7:0]  ERAM_WIN_LO        = 8'h40;    // direct banking window start
  localparam logic [7:0]  ERAM_WIN_HI        = 8'h7f;    // direct banking window end
  localparam logic [9:0]  ERAM_LOG_XRAM_BASE = 10'h100;  // expanded RAM in logical space
  localparam logic [7:0]  ERAM_SFR_BASE      = 8'h80;    // direct addresses from here are registers

  // Where an access lands
  typedef enum logic [1:0] {
    ERAM_TGT_SCRATCH = 2'h0,
    ERAM_TGT_XRAM    = 2'h1,
    ERAM_TGT_OFFCHIP = 2'h2,
    ERAM_TGT_SFR     = 2'h3
  } eram_tgt_t;

  // External-move request from the core
  typedef struct packed {
    logic        valid;  // One-cycle request
    logic        wide;   // 1: wide_pointer form, 0: indirect_pointer_register form
    logic [15:0] ptr;    // wide_pointer value
    logic [7:0]  ri;     // indirect_pointer_register value
    logic [7:0]  port_latch; // port_two_latch value
  } eram_xreq_t;

  // Internal data-memory request from the core
  typedef struct packed {
    logic       valid;    // One-cycle request
    logic       indirect; // 1: indirect internal access, 0: direct address
    logic [7:0] addr;
  } eram_dreq_t;

  // Mapping answer
  typedef struct packed {
    logic        valid;
    eram_tgt_t   tgt;
    logic [15:0] addr;
  } eram_map_t;

  // Special-register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eram_sfr_t;

endpackage : eram_pkg

// >>> rtl/eram_xmove_map.sv
// Purpose: Maps one external-move request onto on-chip expanded RAM or off-chip memory.
// Assumes: Inputs are stable within the cycle; purely combinational.
// Notes:   The top module registers the answer.
`timescale 1ns/100ps
module eram_xmove_map
  import eram_pkg::*;
(
  input  eram_xreq_t xreq,        // Request from the core
  input  logic       xram_enable, // Expanded RAM reachable by external moves
  input  logic [1:0] page_sel,    // page_select_high, page_select_low
  output eram_map_t  xmap         // Target and address
);

  // Route by pointer form, enable and page
  always_comb begin
    xmap       = '0;
    xmap.valid = xreq.valid;
    if (xreq.wide) begin
      // Wide pointer: on chip only below the top of the 768-byte RAM
      if (xram_enable && (xreq.ptr < ERAM_XRAM_SIZE)) begin
        xmap.tgt  = ERAM_TGT_XRAM;
        xmap.addr = xreq.ptr;
      end else begin
        xmap.tgt  = ERAM_TGT_OFFCHIP;
        xmap.addr = xreq.ptr;
      end
    end else begin
      // Indirect pointer: page is honoured only while enabled
      if (xram_enable && (page_sel != ERAM_PAGE_OFFCHIP)) begin
        xmap.tgt  = ERAM_TGT_XRAM;
        xmap.addr = {6'h00, page_sel, xreq.ri};
      end else begin
        xmap.tgt  = ERAM_TGT_OFFCHIP;
        xmap.addr = {xreq.port_latch, xreq.ri};
      end
    end
  end

endmodule : eram_xmove_map

// >>> rtl/eram_direct_map.sv
// Purpose: Maps one internal data-memory request through the direct banking window.
// Assumes: Inputs are stable within the cycle; purely combinational.
// Notes:   Logical 0x000-0x0FF is scratchpad, 0x100-0x3FF is expanded RAM 0x000-0x2FF.
`timescale 1ns/100ps
module eram_direct_map
  import eram_pkg::*;
(
  input  eram_dreq_t dreq,           // Request from the core
  input  logic       banking_enable, // Window mapping on
  input  logic [3:0] bank_number,    // Selected 64-byte bank
  output eram_map_t  dmap            // Target and address
);

  logic [9:0] logical; // Address in the unified 1 KB space

  // Window hit forms a logical address; everything else stays plain
  always_comb begin
    logical    = {bank_number, dreq.addr[5:0]};
    dmap       = '0;
    dmap.valid = dreq.valid;
    if (!dreq.indirect && banking_enable &&
        (dreq.addr >= ERAM_WIN_LO) && (dreq.addr <= ERAM_WIN_HI)) begin
      if (logical < ERAM_LOG_XRAM_BASE) begin
        dmap.tgt  = ERAM_TGT_SCRATCH;
        dmap.addr = {8'h00, logical[7:0]};
      end else begin
        dmap.tgt  = ERAM_TGT_XRAM;
        dmap.addr = {6'h00, logical - ERAM_LOG_XRAM_BASE};
      end
    end else if (!dreq.indirect && (dreq.addr >= ERAM_SFR_BASE)) begin
      // Direct upper half is the register space
      dmap.tgt  = ERAM_TGT_SFR;
      dmap.addr = {8'h00, dreq.addr};
    end else begin
      dmap.tgt  = ERAM_TGT_SCRATCH;
      dmap.addr = {8'h00, dreq.addr};
    end
  end

endmodule : eram_direct_map

// >>> rtl/eram_mapper.sv
// Purpose: Expanded RAM address mapper: steers core data accesses to scratchpad,
//          on-chip expanded RAM or off-chip memory, and holds its control registers.
// Assumes: Core requests and register accesses arrive on clk_sys from core logic.
// Notes:   Answers appear one clock after the request.
`timescale 1ns/100ps
module eram_mapper
  import eram_pkg::*;
(
  input  logic       clk_sys,     // 25 MHz core clock
  input  logic       nrst,        // Asynchronous reset, active low
  input  eram_sfr_t  sfr_req,     // Special-register access
  input  eram_xreq_t xreq,        // External-move request
  input  eram_dreq_t dreq,        // Internal data-memory request
  output logic [7:0] sfr_rdata,   // Read data, one clock after the read
  output logic       sfr_rack,    // Read answered by this block
  output eram_map_t  xmap,        // External-move mapping answer
  output eram_map_t  dmap,        // Internal mapping answer
  output logic       xram_enable, // Current expanded RAM enable
  output logic       banking_on   // Current banking enable
);

  // Clocked state of the mapper, apart from the two reset-release flops
  typedef struct packed {
    logic [1:0] page_sel;  // page_select_high, page_select_low
    logic       bank_en;   // banking_enable
    logic [3:0] bank;      // bank_number
    logic       xen;       // xram_enable
    logic [7:0] rdata;     // Registered read data
    logic       rack;      // Registered read answer
    eram_map_t  xmap;      // Registered external-move answer
    eram_map_t  dmap;      // Registered internal answer
  } eram_state_t;

  eram_state_t st_q;       // Present state
  eram_state_t st_d;       // Next state
  logic        rst_meta_n; // Reset release, first stage
  logic        rst_n;      // Reset release, synchronised
  eram_map_t   xmap_c;     // Combinational external-move answer
  eram_map_t   dmap_c;     // Combinational internal answer

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // External-move routing uses the registers as they stand this cycle
  eram_xmove_map u_xmove_map (
    .xreq        (xreq),
    .xram_enable (st_q.xen),
    .page_sel    (st_q.page_sel),
    .xmap        (xmap_c)
  );

  // Direct banking window
  eram_direct_map u_direct_map (
    .dreq           (dreq),
    .banking_enable (st_q.bank_en),
    .bank_number    (st_q.bank),
    .dmap           (dmap_c)
  );

  // Next state: register writes, read answer and mapping capture
  always_comb begin
    st_d      = st_q;
    st_d.rack = 1'b0;
    st_d.rdata = 8'h00;

    // Register writes; unused bits are dropped
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        ERAM_OFS_PAGE: begin
          st_d.page_sel = {sfr_req.wdata[ERAM_POS_PAGE_HI], sfr_req.wdata[ERAM_POS_PAGE_LO]};
        end
        ERAM_OFS_BANK: begin
          st_d.bank_en = sfr_req.wdata[ERAM_POS_BANK_EN];
          st_d.bank = sfr_req.wdata[ERAM_POS_BANK_HI:0];
        end
        ERAM_OFS_SYSCFG: begin
          st_d.xen = sfr_req.wdata[ERAM_POS_XEN];
        end
        default: begin
          // Not ours; leave state alone
        end
      endcase
    end

    // Register reads; bits without a field read zero
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        ERAM_OFS_PAGE: begin
          st_d.rack  = 1'b1;
          st_d.rdata = {6'h00, st_q.page_sel};
        end
        ERAM_OFS_BANK: begin
          st_d.rack  = 1'b1;
          st_d.rdata = {st_q.bank_en, 3'h0, st_q.bank};
        end
        ERAM_OFS_SYSCFG: begin
          st_d.rack  = 1'b1;
          st_d.rdata = {6'h00, st_q.xen, 1'b0};
        end
        default: begin
          // Another block answers
          st_d.rack  = 1'b0;
          st_d.rdata = 8'h00;
        end
      endcase
    end

    // Capture mapping answers; valid follows the request
    st_d.xmap = xmap_c;
    st_d.dmap = dmap_c;
  end

  // State register; reset values make the enable one and banking off at bank 1
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.page_sel <= ERAM_RST_PAGE[1:0];
      st_q.bank_en  <= ERAM_RST_BANK[ERAM_POS_BANK_EN];
      st_q.bank     <= ERAM_RST_BANK[ERAM_POS_BANK_HI:0];
      st_q.xen      <= ERAM_RST_SYSCFG[ERAM_POS_XEN];
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign sfr_rdata   = st_q.rdata;
  assign sfr_rack    = st_q.rack;
  assign xmap        = st_q.xmap;
  assign dmap        = st_q.dmap;
  assign xram_enable = st_q.xen;
  assign banking_on  = st_q.bank_en;

endmodule : eram_mapper

// >>> testbench/eram_mapper_checker.sv
// Purpose: Port assertions for the expanded RAM mapper.
// Assumes: Page and bank are shadowed from register writes.
// Notes:   Bound into every mapper instance.
`timescale 1ns/100ps
module eram_mapper_checker
  import eram_pkg::*;
(
  input logic       clk_sys,
  input logic       nrst,
  input eram_sfr_t  sfr_req,
  input eram_xreq_t xreq,
  input eram_dreq_t dreq,
  input logic [7:0] sfr_rdata,
  input logic       sfr_rack,
  input eram_map_t  xmap,
  input eram_map_t  dmap,
  input logic       xram_enable,
  input logic       banking_on
);
  logic [1:0] pg_q;  // Page field as last written
  logic [3:0] bk_q;  // Bank number as last written
  logic [9:0] lg;    // Logical address in the window
  logic [9:0] la;    // Physical address of that place
  eram_tgt_t  lt;    // Memory holding that place
  // Shadow of the two mapping registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pg_q <= 2'h0;
      bk_q <= 4'h1;
    end else if (sfr_req.wr && sfr_req.addr == ERAM_OFS_PAGE) begin
      pg_q <= sfr_req.wdata[1:0];
    end else if (sfr_req.wr && sfr_req.addr == ERAM_OFS_BANK) begin
      bk_q <= sfr_req.wdata[3:0];
    end
  end
  assign lg = {bk_q, dreq.addr[5:0]};
  assign lt = (lg < 10'h100) ? ERAM_TGT_SCRATCH : ERAM_TGT_XRAM;
  assign la = (lg < 10'h100) ? lg : lg - 10'h100;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wide_s;
    xreq.valid && xreq.wide;
  endsequence
  sequence ri_s;
    xreq.valid && !xreq.wide;
  endsequence
  sequence win_s;
    dreq.valid && !dreq.indirect && dreq.addr inside {[8'h40:8'h7f]} && banking_on;
  endsequence
  wide_xram_a: assert property (wide_s ##0 (xram_enable && xreq.ptr < 16'h0300)
    |=> xmap == {1'b1, ERAM_TGT_XRAM, $past(xreq.ptr)}) else $error("wide pointer not on chip");
  wide_off_a: assert property (wide_s ##0 (!xram_enable || xreq.ptr >= 16'h0300)
    |=> xmap == {1'b1, ERAM_TGT_OFFCHIP, $past(xreq.ptr)}) else $error("wide pointer not off chip");
  ri_xram_a: assert property (ri_s ##0 (xram_enable && pg_q != 2'h3)
    |=> xmap == {1'b1, ERAM_TGT_XRAM, 6'h00, $past(pg_q), $past(xreq.ri)}) else $error("page map wrong");
  ri_off_a: assert property (ri_s ##0 (!xram_enable || pg_q == 2'h3)
    |=> xmap == {1'b1, ERAM_TGT_OFFCHIP, $past(xreq.port_latch), $past(xreq.ri)}) else $error("port latch map wrong");
  bank_win_a: assert property (win_s |=> dmap == {1'b1, $past(lt), 6'h00, $past(la)})
    else $error("window map wrong");
  plain_dir_a: assert property (dreq.valid && (dreq.indirect || dreq.addr < 8'h40
    || (dreq.addr < 8'h80 && !banking_on)) |=> dmap == {1'b1, ERAM_TGT_SCRATCH, 8'h00, $past(dreq.addr)})
    else $error("plain access remapped");
  sfr_dir_a: assert property (dreq.valid && !dreq.indirect && dreq.addr >= 8'h80
    |=> dmap == {1'b1, ERAM_TGT_SFR, 8'h00, $past(dreq.addr)}) else $error("register access remapped");
  rd_ack_a: assert property (sfr_req.rd |=> sfr_rack == $past(sfr_req.addr inside {8'h85, 8'h86, 8'hbf}))
    else $error("read answer wrong");
  xen_rd_a: assert property (sfr_req.rd && sfr_req.addr == 8'hbf
    |=> sfr_rdata == {6'h00, $past(xram_enable), 1'b0}) else $error("enable read wrong");
  en_rst_a: assert property ($rose(nrst) |-> xram_enable) else $error("enable not set at reset");
endmodule : eram_mapper_checker
bind eram_mapper eram_mapper_checker i_chk (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req), .xreq(xreq),
  .dreq(dreq), .sfr_rdata(sfr_rdata), .sfr_rack(sfr_rack), .xmap(xmap), .dmap(dmap),
  .xram_enable(xram_enable), .banking_on(banking_on));

// >>> testbench/eram_core_model.sv
// Purpose: Core model issuing register and memory accesses.
// Assumes: Requests change on the falling clock edge.
// Notes:   Strobes drop and the remaining fields are inverted once released.
`timescale 1ns/100ps
module eram_core_model
  import eram_pkg::*;
(
  input  logic       clk_sys,
  output eram_sfr_t  sfr_req,
  output eram_xreq_t xreq,
  output eram_dreq_t dreq,
  input  logic [7:0] sfr_rdata,
  input  logic       sfr_rack,
  input  eram_map_t  xmap,
  input  eram_map_t  dmap
);
  // Idle at time zero
  initial begin
    sfr_req = '0;
    xreq = '0;
    dreq = '0;
  end
  // Register write, strobe for one cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req = {2'b10, a, d};
    @(negedge clk_sys);
    sfr_req = {2'b00, ~sfr_req[15:0]};
  endtask : wr
  // Register read, answer taken one cycle later
  task rd(input logic [7:0] a, output logic [8:0] r);
    @(negedge clk_sys);
    sfr_req = {2'b01, a, 8'h00};
    @(negedge clk_sys);
    r = {sfr_rack, sfr_rdata};
    sfr_req = {2'b00, ~sfr_req[15:0]};
  endtask : rd
  // External move request
  task xm(input logic w, input logic [15:0] p, input logic [7:0] ri, input logic [7:0] pl, output eram_map_t m);
    @(negedge clk_sys);
    xreq = {1'b1, w, p, ri, pl};
    @(negedge clk_sys);
    m = xmap;
    xreq = {1'b0, ~xreq[32:0]};
  endtask : xm
  // Internal data request
  task dm(input logic ind, input logic [7:0] a, output eram_map_t m);
    @(negedge clk_sys);
    dreq = {1'b1, ind, a};
    @(negedge clk_sys);
    m = dmap;
    dreq = {1'b0, ~dreq[8:0]};
  endtask : dm
endmodule : eram_core_model

// >>> testbench/eram_mapper_tb.sv
// Purpose: Self-checking bench of the expanded RAM mapper.
// Assumes: Core model drives all requests.
// Notes:   Expected maps are worked out here.
`timescale 1ns/100ps
module eram_mapper_tb;
  import eram_pkg::*;
  logic       clk_sys = 1'b0; // Core clock
  logic       nrst = 1'b0;    // Reset, active low
  eram_sfr_t  sfr_req;
  eram_xreq_t xreq;
  eram_dreq_t dreq;
  logic [7:0] sfr_rdata;
  logic       sfr_rack;
  eram_map_t  xmap;
  eram_map_t  dmap;
  logic       xram_enable;
  logic       banking_on;
  int         errors = 0;
  int         checked = 0;
  eram_map_t  m;
  logic [8:0] r;
  logic [9:0] lg;
  logic [15:0] p [4] = '{16'h0000, 16'h02ff, 16'h0300, 16'hffff};
  always #20 clk_sys = ~clk_sys;
  eram_mapper i_dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req), .xreq(xreq), .dreq(dreq),
    .sfr_rdata(sfr_rdata), .sfr_rack(sfr_rack), .xmap(xmap), .dmap(dmap), .xram_enable(xram_enable),
    .banking_on(banking_on));
  eram_core_model i_core (.clk_sys(clk_sys), .sfr_req(sfr_req), .xreq(xreq), .dreq(dreq),
    .sfr_rdata(sfr_rdata), .sfr_rack(sfr_rack), .xmap(xmap), .dmap(dmap));
  task chk(input logic [18:0] got, input logic [18:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reset values and an unmapped read
  task t_reset;
    i_core.rd(ERAM_OFS_PAGE, r);
    chk({10'h000, r}, 19'h0_0100);
    i_core.rd(ERAM_OFS_BANK, r);
    chk({10'h000, r}, 19'h0_0101);
    i_core.rd(ERAM_OFS_SYSCFG, r);
    chk({10'h000, r}, 19'h0_0102);
    i_core.rd(8'h87, r);
    chk({10'h000, r}, 19'h0_0000);
    chk({17'h0_0000, xram_enable, banking_on}, 19'h0_0002);
  endtask : t_reset
  // Wide pointer on both sides of 768, then disabled
  task t_wide;
    for (int i = 0; i < 4; i++) begin
      i_core.xm(1'b1, p[i], 8'h00, 8'h00, m);
      chk(m, {1'b1, (i < 2) ? ERAM_TGT_XRAM : ERAM_TGT_OFFCHIP, p[i]});
    end
    i_core.wr(ERAM_OFS_SYSCFG, 8'h00);
    i_core.xm(1'b1, 16'h0100, 8'h00, 8'h00, m);
    chk(m, {1'b1, ERAM_TGT_OFFCHIP, 16'h0100});
    i_core.wr(ERAM_OFS_SYSCFG, 8'h02);
  endtask : t_wide
  // Every page code, then page 1 while disabled
  task t_page;
    for (int g = 0; g < 4; g++) begin
      i_core.wr(ERAM_OFS_PAGE, 8'(g));
      i_core.xm(1'b0, 16'h0000, 8'h5a, 8'hc3, m);
      chk(m, (g < 3) ? {1'b1, ERAM_TGT_XRAM, 6'h00, 2'(g), 8'h5a} : {1'b1, ERAM_TGT_OFFCHIP, 16'hc35a});
    end
    i_core.wr(ERAM_OFS_PAGE, 8'h01);
    i_core.wr(ERAM_OFS_SYSCFG, 8'h00);
    i_core.xm(1'b0, 16'h0000, 8'h5a, 8'hc3, m);
    chk(m, {1'b1, ERAM_TGT_OFFCHIP, 16'hc35a});
    i_core.wr(ERAM_OFS_SYSCFG, 8'h02);
  endtask : t_page
  // All sixteen banks, then plain and disabled accesses
  task t_bank;
    for (int b = 0; b < 16; b++) begin
      i_core.wr(ERAM_OFS_BANK, 8'h80 | 8'(b));
      i_core.dm(1'b0, 8'h41, m);
      lg = {4'(b), 6'h01};
      chk(m, {1'b1, (b < 4) ? ERAM_TGT_SCRATCH : ERAM_TGT_XRAM, 6'h00, (b < 4) ? lg : lg - 10'h100});
    end
    i_core.rd(ERAM_OFS_BANK, r);
    chk({10'h000, r}, 19'h0_018f);
    chk({18'h0_0000, banking_on}, 19'h0_0001);
    i_core.dm(1'b0, 8'h3f, m);
    chk(m, {1'b1, ERAM_TGT_SCRATCH, 16'h003f});
    i_core.dm(1'b0, 8'h90, m);
    chk(m, {1'b1, ERAM_TGT_SFR, 16'h0090});
    i_core.dm(1'b1, 8'h41, m);
    chk(m, {1'b1, ERAM_TGT_SCRATCH, 16'h0041});
    i_core.wr(ERAM_OFS_BANK, 8'h0f);
    chk({18'h0_0000, banking_on}, 19'h0_0000);
    i_core.dm(1'b0, 8'h41, m);
    chk(m, {1'b1, ERAM_TGT_SCRATCH, 16'h0041});
  endtask : t_bank
  task give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_wide();
    t_page();
    t_bank();
    give_verdict();
  end
  // Watchdog
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule : eram_mapper_tb
